// ==== rtl/srh_host.v ====
// Purpose: host controller driving a 16K x 1 asynchronous static ram
// Assumes: one 50 MHz clock; ram pins are plain outputs plus one data input
// Notes:   read and write requests on a simple req/ack port; one access at a time
//          select is strobed per access, so the part idles at standby power
//          writes are strobe-controlled: strobe rises one cycle before select
//          timing counts round the fastest grade up to whole clock cycles
//          a slower grade needs the ns figures in the header raised to match
//          the returned bit is resynchronised, costing two cycles of read latency
//
// Behaviour
// - write spans later fall to first rise
// - address setup before strobe, held past rise
// - never change address inside write pulse
// - write data valid before strobe rises
// - select-controlled write referenced to select rise
// - write data held after terminating edge
// - wait 2 ms after power-up
// - each cycle at least access time long
`include "srh_consts.vh"

module srh_host #(
    parameter ADDR_W      = `SRH_ADDR_W,
    parameter POWERUP_CYC = (`SRH_POWERUP_US * 1000) / `SRH_CLK_PERIOD_NS
)(
    input  wire              clk_i,
    input  wire              nrst_i,
    input  wire              req_i,
    input  wire              req_write_i,
    input  wire [ADDR_W-1:0] req_addr_i,
    input  wire              req_bit_i,
    output reg               ready_o,
    output reg               ack_o,
    output reg               rd_bit_o,
    output reg [ADDR_W-1:0]  cell_index_lines_o,
    output reg               sel_n_o,
    output reg               wr_n_o,
    output reg               din_o,
    input  wire              dout_i
);
    function [7:0] cyc_min;
        input integer ns;
        integer cyc;
        begin
            cyc = (ns + `SRH_CLK_PERIOD_NS - 1) / `SRH_CLK_PERIOD_NS;
            // a zero requirement still costs one state cycle
            if (cyc < 1)
                cyc = 1;
            cyc_min = cyc[7:0];
        end
    endfunction

    // two extra cycles cover the two-flop sampling of the returned bit
    localparam [7:0] RD_CYC    = cyc_min(`SRH_ACCESS_NS) + 8'h02;
    localparam [7:0] SETUP_CYC = cyc_min(`SRH_ADDR_SETUP_NS);
    // pulse takes the cycle time less setup; this also covers the data-valid lead
    localparam [7:0] PULSE_CYC = cyc_min(`SRH_CYCLE_NS - `SRH_ADDR_SETUP_NS);
    localparam [7:0] HOLD_CYC  = cyc_min(`SRH_DATA_HOLD_NS);

    localparam [5:0] ST_PWR   = 6'h01;
    localparam [5:0] ST_IDLE  = 6'h02;
    localparam [5:0] ST_READ  = 6'h04;
    localparam [5:0] ST_SETUP = 6'h08;
    localparam [5:0] ST_PULSE = 6'h10;
    localparam [5:0] ST_HOLD  = 6'h20;

    reg  [5:0]  state_reg;
    // wide enough for the full power-up wait at any sensible clock
    reg  [31:0] pwr_cnt_reg;
    reg  [7:0]  cnt_reg;
    reg         dout_meta_reg;
    reg         dout_sync_reg;

    // the returned bit comes from an unclocked part: two flops before use
    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            dout_meta_reg <= 1'b0;
            dout_sync_reg <= 1'b0;
        end
        else
        begin
            dout_meta_reg <= dout_i;
            dout_sync_reg <= dout_meta_reg;
        end
    end

    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state_reg          <= ST_PWR;
            pwr_cnt_reg        <= 32'h0;
            cnt_reg            <= 8'h00;
            ready_o            <= 1'b0;
            ack_o              <= 1'b0;
            rd_bit_o           <= 1'b0;
            cell_index_lines_o <= {ADDR_W{1'b0}};
            sel_n_o            <= 1'b1;
            wr_n_o             <= 1'b1;
            din_o              <= 1'b0;
        end
        else
        begin
            ack_o <= 1'b0;
            case (state_reg)
                ST_PWR:
                begin
                    // no access until the part's substrate pump has settled
                    if (pwr_cnt_reg >= POWERUP_CYC - 1)
                    begin
                        state_reg <= ST_IDLE;
                        ready_o   <= 1'b1;
                    end
                    else
                        pwr_cnt_reg <= pwr_cnt_reg + 32'h1;
                end
                ST_IDLE:
                begin
                    if (req_i)
                    begin
                        ready_o            <= 1'b0;
                        // address only moves here, after select has risen
                        cell_index_lines_o <= req_addr_i;
                        din_o              <= req_bit_i;
                        // strobed select: address and select change together
                        sel_n_o            <= 1'b0;
                        if (req_write_i)
                        begin
                            wr_n_o    <= 1'b1;
                            cnt_reg   <= SETUP_CYC;
                            state_reg <= ST_SETUP;
                        end
                        else
                        begin
                            wr_n_o    <= 1'b1;
                            cnt_reg   <= RD_CYC;
                            state_reg <= ST_READ;
                        end
                    end
                    else
                    begin
                        // idle keeps the part deselected so it sits at standby power
                        sel_n_o <= 1'b1;
                        wr_n_o  <= 1'b1;
                    end
                end
                ST_READ:
                begin
                    if (cnt_reg == 8'h01)
                    begin
                        // sample only after full access; bit stable while address held
                        // the brief old-bit hold after an address move is long past here
                        rd_bit_o  <= dout_sync_reg;
                        ack_o     <= 1'b1;
                        sel_n_o   <= 1'b1;
                        ready_o   <= 1'b1;
                        state_reg <= ST_IDLE;
                    end
                    else
                        cnt_reg <= cnt_reg - 8'h01;
                end
                ST_SETUP:
                begin
                    // strobe falls a full cycle after the address has settled
                    if (cnt_reg == 8'h01)
                    begin
                        wr_n_o    <= 1'b0;
                        cnt_reg   <= PULSE_CYC;
                        state_reg <= ST_PULSE;
                    end
                    else
                        cnt_reg <= cnt_reg - 8'h01;
                end
                ST_PULSE:
                begin
                    // address and data frozen for the whole pulse
                    if (cnt_reg == 8'h01)
                    begin
                        wr_n_o    <= 1'b1;
                        cnt_reg   <= HOLD_CYC;
                        state_reg <= ST_HOLD;
                    end
                    else
                        cnt_reg <= cnt_reg - 8'h01;
                end
                ST_HOLD:
                begin
                    // select drops with strobe risen; address and data kept past it
                    sel_n_o <= 1'b1;
                    if (cnt_reg == 8'h01)
                    begin
                        ack_o     <= 1'b1;
                        ready_o   <= 1'b1;
                        state_reg <= ST_IDLE;
                    end
                    else
                        cnt_reg <= cnt_reg - 8'h01;
                end
                default:
                begin
                    // an illegal state code parks the pins and re-enters ST_PWR without clearing the wait count
                    state_reg <= ST_PWR;
                    sel_n_o   <= 1'b1;
                    wr_n_o    <= 1'b1;
                end
            endcase
        end
    end
endmodule

// ==== rtl/srh_consts.vh ====
// Purpose: timing constants for the static ram host controller
// Assumes: 50 MHz clock, 20 ns period; fastest speed grade figures
// Notes:   times in ns (power-up in us), cycle counts derived in the module
`ifndef SRH_CONSTS_VH
`define SRH_CONSTS_VH
`define SRH_CLK_PERIOD_NS      20
`define SRH_ADDR_W             14
`define SRH_DEPTH              16384
`define SRH_ACCESS_NS          70
`define SRH_CYCLE_NS           70
`define SRH_ADDR_SETUP_NS      10
`define SRH_WRITE_RECOV_NS     0
`define SRH_DATA_VALID_NS      30
`define SRH_WRITE_PULSE_NS     40
`define SRH_DATA_HOLD_NS       10
`define SRH_POWERUP_US         2000
`endif

// ==== dv/srh_host_props.sv ====
// Purpose: port-level checks on the static ram host controller
// Assumes: one clock domain, async active-low reset
// Notes:   power-up window counted in helper logic
module srh_host_props #(
    parameter ADDR_W      = 14,
    parameter POWERUP_CYC = 10
)(
    input wire              clk_i,
    input wire              nrst_i,
    input wire              ready_o,
    input wire              ack_o,
    input wire [ADDR_W-1:0] cell_index_lines_o,
    input wire              sel_n_o,
    input wire              wr_n_o,
    input wire              din_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    int up_cnt;
    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            up_cnt <= 0;
        else if (up_cnt < POWERUP_CYC)
            up_cnt <= up_cnt + 1;
    end
    a_wait_powerup: assert property ((up_cnt < POWERUP_CYC) |-> sel_n_o && !ready_o)
        else $error("access started during power-up wait");
    a_write_in_sel: assert property (!wr_n_o |-> !sel_n_o)
        else $error("write strobe low while deselected");
    a_setup_before_strobe: assert property ($fell(wr_n_o) |-> $stable(cell_index_lines_o))
        else $error("address moved at strobe fall");
    a_addr_held_access: assert property (!sel_n_o && $past(!sel_n_o) |-> $stable(cell_index_lines_o))
        else $error("address changed inside an access");
    a_pulse_width: assert property ($fell(wr_n_o) |-> !wr_n_o [*3] ##1 wr_n_o)
        else $error("write pulse not three cycles");
    a_data_hold: assert property ($rose(wr_n_o) |-> $stable(din_o) && !sel_n_o)
        else $error("write bit or select dropped at strobe rise");
    a_cycle_length: assert property ($fell(sel_n_o) |-> !sel_n_o [*4])
        else $error("access shorter than cycle time");
    a_ack_ends_access: assert property ($rose(sel_n_o) |-> ack_o && ready_o)
        else $error("deselect without completion");
    cover property ($fell(wr_n_o));
    cover property ($rose(sel_n_o) && wr_n_o);
    cover property (ack_o ##1 !ready_o);
endmodule

bind srh_host srh_host_props #(.ADDR_W(ADDR_W), .POWERUP_CYC(POWERUP_CYC)) u_props (
    .clk_i(clk_i), .nrst_i(nrst_i), .ready_o(ready_o), .ack_o(ack_o),
    .cell_index_lines_o(cell_index_lines_o), .sel_n_o(sel_n_o), .wr_n_o(wr_n_o), .din_o(din_o));

// ==== dv/srh_ram_model.sv ====
// Purpose: behavioural 16K x 1 static ram for the host bench
// Assumes: access delay fixed by ACC_NS
// Notes:   unsettled or floating output toggles so stale bits never match
module srh_ram_model #(
    parameter ACC_NS = 70
)(
    input  wire        sel_n_i,
    input  wire        wr_n_i,
    input  wire [13:0] addr_i,
    input  wire        din_i,
    output reg         dout_o
);
    timeunit 1ns;
    timeprecision 1ns;
    reg      mem [0:16383];
    reg      junk = 1'b0;
    realtime t_chg = 0;
    always #7 junk = ~junk;
    // old bit is not held after a change: the host must never rely on it
    always @(negedge sel_n_i or addr_i or posedge wr_n_i) t_chg = $realtime;
    always @(posedge wr_n_i or posedge sel_n_i)
        if (wr_n_i ^ sel_n_i) mem[addr_i] = din_i;
    always @(junk or sel_n_i or wr_n_i or addr_i)
        dout_o = (!sel_n_i && wr_n_i && ($realtime - t_chg >= ACC_NS)) ?
                 mem[addr_i] : junk;
endmodule

// ==== dv/srh_host_tb.sv ====
// Purpose: self-checking bench for the static ram host controller
// Assumes: power-up wait shortened to 10 cycles
// Notes:   inputs change on the falling clock edge
module srh_host_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam P = 10;
    logic clk_i = 1'b0;
    logic nrst_i, req_i, req_write_i, req_bit_i, ready_o, ack_o, rd_bit_o;
    logic sel_n_o, wr_n_o, din_o, dout_i;
    logic [13:0] req_addr_i, cell_index_lines_o;
    int errors = 0;
    int check_count = 0;
    srh_host #(.POWERUP_CYC(P)) dut (.clk_i(clk_i), .nrst_i(nrst_i), .req_i(req_i),
        .req_write_i(req_write_i), .req_addr_i(req_addr_i), .req_bit_i(req_bit_i),
        .ready_o(ready_o), .ack_o(ack_o), .rd_bit_o(rd_bit_o),
        .cell_index_lines_o(cell_index_lines_o), .sel_n_o(sel_n_o), .wr_n_o(wr_n_o),
        .din_o(din_o), .dout_i(dout_i));
    srh_ram_model u_ram (.sel_n_i(sel_n_o), .wr_n_i(wr_n_o), .addr_i(cell_index_lines_o),
        .din_i(din_o), .dout_o(dout_i));
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    // request held high through reset so an early take would show
    task automatic reset_powerup;
        int n;
        nrst_i = 0;
        req_i = 1;
        repeat (6) @(negedge clk_i);
        nrst_i = 1;
        n = 0;
        while (ready_o !== 1'b1 && n < 30)
        begin
            @(negedge clk_i);
            n++;
        end
        req_i = 0;
        @(negedge clk_i);
        chk("powerup_cycles", n, P);
        chk("sel_idle", sel_n_o, 1);
        if (n >= 30)
            tally_and_finish();
    endtask
    task automatic access(input logic w, input logic [13:0] a, input logic b, input int lat);
        int n;
        req_write_i = w;
        req_addr_i = a;
        req_bit_i = b;
        req_i = 1;
        @(posedge clk_i);
        @(negedge clk_i);
        req_i = 0;
        n = 0;
        while (ack_o !== 1'b1 && n < 20)
        begin
            @(negedge clk_i);
            n++;
        end
        chk("latency", n, lat);
        if (n >= 20)
            tally_and_finish();
    endtask
    // corner and alternating addresses catch decode faults
    task automatic write_read_table;
        logic [13:0] ad [4] = '{14'h0000, 14'h3FFF, 14'h2AAA, 14'h1555};
        for (int i = 0; i < 4; i++)
            access(1'b1, ad[i], ~i[0], 5);
        for (int i = 0; i < 4; i++)
        begin
            access(1'b0, ad[i], 1'b0, 6);
            chk("read_bit", rd_bit_o, {~i[0]});
        end
    endtask
    task automatic overwrite_back_to_back;
        access(1'b1, 14'h3FFF, 1'b1, 5);
        access(1'b0, 14'h3FFF, 1'b0, 6);
        chk("rewrite_bit", rd_bit_o, 1);
        reset_powerup();
        access(1'b0, 14'h2AAA, 1'b0, 6);
        chk("kept_bit", rd_bit_o, 1);
    endtask
    initial
    begin
        clk_i = 0;
        forever #10 clk_i = ~clk_i;
    end
    initial
    begin
        {req_write_i, req_bit_i} = '0;
        req_addr_i = '0;
        reset_powerup();
        write_read_table();
        overwrite_back_to_back();
        tally_and_finish();
    end
endmodule
